// file: verilog/scpt_timer.sv
`timescale 1ns/1ps
// Behaviour
// - mode 0101 forces reference high, polarity applied
// - mode 0100 forces reference low
// - forced output still compares and flags
// - match actions: keep, active, inactive, toggle
// - counter equal compare sets compare flag
// - compare irq only when flag and enable
// - compare preload defers load to update
// - update event changes compare output only through PWM levels or a new match
// - modes 0110 and 0111 select PWM 1/2
// - PWM1 high while count below compare
// - edge-aligned PWM only, upcounting
// - single-shot clears run bit at update
// - mirror copies update flag to bit 31
// - filter divide 1, 2 or 4 clocks
// - period preload buffers period until update
// - update source selects overflow-only updates
// - update disable blocks update, still reinitialises
// - counter runs only while run bit set
// - count 0 to period, overflow, restart
// - update generation clears counters, self-clears
// - update flag rules for overflow and reinit
module scpt_timer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // outputs
    output logic             compare_output_pin,
    output logic             compare_irq,
    output logic             update_irq,
    output logic             filter_sample_clock
);
    if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
        $error("scpt_timer: WIDTH must be 2..16");
    end

    logic [15:0]      ctrl_reg;
    logic [1:0]       irq_en_reg;
    logic             update_flag_reg;
    logic             compare_flag_reg;
    logic [6:0]       mode_reg;
    logic [1:0]       outcfg_reg;
    logic [WIDTH-1:0] psc_pre_reg;
    logic [WIDTH-1:0] psc_shadow_reg;
    logic [WIDTH-1:0] period_pre_reg;
    logic [WIDTH-1:0] period_shadow_reg;
    logic [WIDTH-1:0] cmp_pre_reg;
    logic [WIDTH-1:0] cmp_shadow_reg;
    logic             reference_waveform;
    logic [WIDTH-1:0] count_value;
    logic             overflow;
    logic             match_reg;

    logic             wr_ctrl;
    logic             wr_event;
    logic             ug_now;
    logic             update_event;
    logic             reinit;
    logic             cmp_match;
    logic             cnt_load;
    scpt_pkg::scpt_mode_t compare_mode_field;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_ctrl            = reg_write && hit(reg_addr, scpt_pkg::OFS_CTRL);
    assign wr_event           = reg_write && hit(reg_addr, scpt_pkg::OFS_EVENT);
    assign ug_now             = wr_event && reg_wdata[scpt_pkg::EV_UPD];
    assign cnt_load           = reg_write && hit(reg_addr, scpt_pkg::OFS_COUNT);
    assign compare_mode_field = scpt_pkg::scpt_mode_t'({1'b0, mode_reg[scpt_pkg::MODE_FLD +: 3]});
    // update generation is a strobe that nothing holds, so it reads back zero
    assign reinit             = ug_now;
    // update disable blocks both sources; update source masks the software one
    assign update_event = !ctrl_reg[scpt_pkg::CTRL_UPDATE_DISABLE] &&
                          (overflow || (ug_now && !ctrl_reg[scpt_pkg::CTRL_USRC]));
    assign cmp_match    = ctrl_reg[scpt_pkg::CTRL_RUN] && (count_value == cmp_shadow_reg);

    scpt_counter #(
        .WIDTH (WIDTH)
    ) u_counter (
        .clock       (clock),
        .rst_b       (rst_b),
        .run         (ctrl_reg[scpt_pkg::CTRL_RUN]),
        .reinit      (reinit),
        .psc_ratio   (psc_shadow_reg),
        .period      (period_shadow_reg),
        .load_en     (cnt_load),
        .load_value  (reg_wdata[WIDTH-1:0]),
        .count_value (count_value),
        .overflow    (overflow)
    );

    scpt_filter_clk u_filter (
        .clock       (clock),
        .rst_b       (rst_b),
        .divide      (ctrl_reg[scpt_pkg::CTRL_FDIV +: 2]),
        .sample_tick (filter_sample_clock)
    );

    // control register; hardware clears run on update in single-shot mode
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_reg <= scpt_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[15:0] & scpt_pkg::CTRL_MASK;
        end else if (update_event && ctrl_reg[scpt_pkg::CTRL_SHOT]) begin
            ctrl_reg[scpt_pkg::CTRL_RUN] <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_en_reg <= 2'h0;
            mode_reg   <= 7'h00;
            outcfg_reg <= 2'h0;
        end else if (reg_write) begin
            if (hit(reg_addr, scpt_pkg::OFS_IRQ_EN)) begin
                irq_en_reg <= reg_wdata[1:0];
            end
            if (hit(reg_addr, scpt_pkg::OFS_MODE)) begin
                mode_reg <= reg_wdata[6:0];
            end
            if (hit(reg_addr, scpt_pkg::OFS_OUTCFG)) begin
                outcfg_reg <= reg_wdata[1:0];
            end
        end
    end

    // preload registers always take writes; shadows load at update or at once
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            period_pre_reg <= WIDTH'(scpt_pkg::PERIOD_RESET);
            psc_pre_reg    <= '0;
            cmp_pre_reg    <= '0;
        end else if (reg_write) begin
            if (hit(reg_addr, scpt_pkg::OFS_PERIOD)) begin
                period_pre_reg <= reg_wdata[WIDTH-1:0];
            end
            if (hit(reg_addr, scpt_pkg::OFS_PRESCALE)) begin
                psc_pre_reg <= reg_wdata[WIDTH-1:0];
            end
            if (hit(reg_addr, scpt_pkg::OFS_COMPARE)) begin
                cmp_pre_reg <= reg_wdata[WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            period_shadow_reg <= WIDTH'(scpt_pkg::PERIOD_RESET);
        end else if (!ctrl_reg[scpt_pkg::CTRL_PPRE]) begin
            period_shadow_reg <= period_pre_reg;
        end else if (update_event) begin
            period_shadow_reg <= period_pre_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            psc_shadow_reg <= '0;
        end else if (update_event) begin
            psc_shadow_reg <= psc_pre_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmp_shadow_reg <= '0;
        end else if (!mode_reg[scpt_pkg::MODE_PRE]) begin
            cmp_shadow_reg <= cmp_pre_reg;
        end else if (update_event) begin
            cmp_shadow_reg <= cmp_pre_reg;
        end
    end

    // flags: hardware set wins over software write-zero clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            update_flag_reg <= 1'b0;
        end else if (update_event) begin
            update_flag_reg <= 1'b1;
        end else if (reg_write && hit(reg_addr, scpt_pkg::OFS_STATUS) &&
                     !reg_wdata[scpt_pkg::ST_UPD]) begin
            update_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= cmp_match;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            compare_flag_reg <= 1'b0;
        end else if ((cmp_match && !match_reg) ||
                     (wr_event && reg_wdata[scpt_pkg::EV_CMP])) begin
            compare_flag_reg <= 1'b1;
        end else if (reg_write && hit(reg_addr, scpt_pkg::OFS_STATUS) &&
                     !reg_wdata[scpt_pkg::ST_CMP]) begin
            compare_flag_reg <= 1'b0;
        end
    end

    // reference waveform; update events play no part here
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reference_waveform <= 1'b0;
        end else if (!mode_reg[scpt_pkg::MODE_DIR]) begin
            case (compare_mode_field)
                scpt_pkg::SCPT_FROZEN:   reference_waveform <= reference_waveform;
                scpt_pkg::SCPT_SET_ACT:  if (cmp_match) reference_waveform <= 1'b1;
                scpt_pkg::SCPT_SET_INA:  if (cmp_match) reference_waveform <= 1'b0;
                scpt_pkg::SCPT_TOGGLE: begin
                    if (cmp_match && !match_reg) begin
                        reference_waveform <= !reference_waveform;
                    end
                end
                scpt_pkg::SCPT_FORCE_LO: reference_waveform <= 1'b0;
                scpt_pkg::SCPT_FORCE_HI: reference_waveform <= 1'b1;
                // edge-aligned only: the counter has no down direction
                scpt_pkg::SCPT_PWM1:     reference_waveform <= (count_value < cmp_shadow_reg);
                scpt_pkg::SCPT_PWM2:     reference_waveform <= !(count_value < cmp_shadow_reg);
                default:                 reference_waveform <= reference_waveform;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            compare_output_pin <= 1'b0;
        end else if (!outcfg_reg[scpt_pkg::OUT_EN]) begin
            compare_output_pin <= 1'b0;
        end else begin
            compare_output_pin <= reference_waveform ^ outcfg_reg[scpt_pkg::OUT_POL];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            compare_irq <= 1'b0;
            update_irq  <= 1'b0;
        end else begin
            compare_irq <= compare_flag_reg && irq_en_reg[scpt_pkg::IE_CMP];
            update_irq  <= update_flag_reg && irq_en_reg[scpt_pkg::IE_UPD];
        end
    end

    // read data one cycle after the strobe, zero otherwise and on unmapped offsets
    always_ff @(posedge clock) begin
        if (!rst_b || !reg_read) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                scpt_pkg::OFS_CTRL:     reg_rdata <= {16'h0000, ctrl_reg};
                scpt_pkg::OFS_IRQ_EN:   reg_rdata <= {30'h0, irq_en_reg};
                scpt_pkg::OFS_STATUS:   reg_rdata <= {30'h0, compare_flag_reg, update_flag_reg};
                scpt_pkg::OFS_MODE:     reg_rdata <= {25'h0, mode_reg};
                scpt_pkg::OFS_OUTCFG:   reg_rdata <= {30'h0, outcfg_reg};
                scpt_pkg::OFS_COUNT:    reg_rdata <= {ctrl_reg[scpt_pkg::CTRL_MIRROR] &&
                                                      update_flag_reg,
                                                      (31 - WIDTH)'(0), count_value};
                scpt_pkg::OFS_PRESCALE: reg_rdata <= 32'(psc_pre_reg);
                scpt_pkg::OFS_PERIOD:   reg_rdata <= 32'(period_pre_reg);
                scpt_pkg::OFS_COMPARE:  reg_rdata <= 32'(cmp_pre_reg);
                default:                reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    a_single_shot_stop: assert property (@(posedge clock) disable iff (!rst_b)
        (update_event && ctrl_reg[scpt_pkg::CTRL_SHOT] && !wr_ctrl)
            |=> !ctrl_reg[scpt_pkg::CTRL_RUN])
        else $error("run bit not cleared after single-shot update");
    a_force_high_pin: assert property (@(posedge clock) disable iff (!rst_b)
        (compare_mode_field == scpt_pkg::SCPT_FORCE_HI && !mode_reg[0] && outcfg_reg == 2'h1)
            [*2] |=> compare_output_pin)
        else $error("forced high not on pin");
    a_force_low_ref: assert property (@(posedge clock) disable iff (!rst_b)
        (compare_mode_field == scpt_pkg::SCPT_FORCE_LO && !mode_reg[0]) |=> !reference_waveform)
        else $error("forced low not on reference");
    a_match_flag: assert property (@(posedge clock) disable iff (!rst_b)
        (cmp_match && !match_reg) |=> compare_flag_reg)
        else $error("match did not set compare flag");
    a_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
        compare_irq |-> $past(compare_flag_reg) && $past(irq_en_reg[1]))
        else $error("compare irq without flag and enable");
    a_ug_clears_cnt: assert property (@(posedge clock) disable iff (!rst_b)
        ug_now |=> count_value == '0)
        else $error("update generation left counter nonzero");
    a_update_disable_no_flag: assert property (@(posedge clock) disable iff (!rst_b)
        (ctrl_reg[1] && !update_flag_reg && !wr_ctrl) |=> !update_flag_reg)
        else $error("update flag set while updates disabled");
    a_hold_stopped: assert property (@(posedge clock) disable iff (!rst_b)
        (!ctrl_reg[0] && !ug_now && !cnt_load) |=> $stable(count_value))
        else $error("counter moved while stopped");
    a_pin_disabled: assert property (@(posedge clock) disable iff (!rst_b)
        !outcfg_reg[0] |=> !compare_output_pin)
        else $error("pin driven while output disabled");
    a_update_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
        update_event |=> update_flag_reg)
        else $error("update event did not set update flag");
    a_pwm1_level: assert property (@(posedge clock) disable iff (!rst_b)
        (compare_mode_field == scpt_pkg::SCPT_PWM1 && !mode_reg[scpt_pkg::MODE_DIR])
            |=> reference_waveform == $past(count_value < cmp_shadow_reg))
        else $error("mode 1 reference not high below compare");
    a_pwm2_level: assert property (@(posedge clock) disable iff (!rst_b)
        (compare_mode_field == scpt_pkg::SCPT_PWM2 && !mode_reg[scpt_pkg::MODE_DIR])
            |=> reference_waveform == $past(count_value >= cmp_shadow_reg))
        else $error("mode 2 reference not low below compare");
    a_period_buffered: assert property (@(posedge clock) disable iff (!rst_b)
        (ctrl_reg[scpt_pkg::CTRL_PPRE] && !update_event) |=> $stable(period_shadow_reg))
        else $error("buffered period changed without update");
    a_cmp_buffered: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_reg[scpt_pkg::MODE_PRE] && !update_event) |=> $stable(cmp_shadow_reg))
        else $error("buffered compare changed without update");
    a_ref_no_update: assert property (@(posedge clock) disable iff (!rst_b)
        (update_event && !cmp_match && !mode_reg[scpt_pkg::MODE_DIR] &&
         compare_mode_field <= scpt_pkg::SCPT_TOGGLE) |=> $stable(reference_waveform))
        else $error("update event moved compare reference");

    c_overflow: cover property (@(posedge clock) disable iff (!rst_b) overflow);
    c_single_shot: cover property (@(posedge clock) disable iff (!rst_b)
        ctrl_reg[3] && update_event);
    c_pwm_run: cover property (@(posedge clock) disable iff (!rst_b)
        compare_mode_field == scpt_pkg::SCPT_PWM1 && reference_waveform);
    c_toggle: cover property (@(posedge clock) disable iff (!rst_b)
        compare_mode_field == scpt_pkg::SCPT_TOGGLE && cmp_match);
    c_period_load: cover property (@(posedge clock) disable iff (!rst_b)
        ctrl_reg[scpt_pkg::CTRL_PPRE] && update_event);
endmodule // scpt_timer

// file: verilog/scpt_pkg.sv
package scpt_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_EVENT    = 8'h14;
    localparam logic [7:0] OFS_MODE     = 8'h18;
    localparam logic [7:0] OFS_OUTCFG   = 8'h20;
    localparam logic [7:0] OFS_COUNT    = 8'h24;
    localparam logic [7:0] OFS_PRESCALE = 8'h28;
    localparam logic [7:0] OFS_PERIOD   = 8'h2C;
    localparam logic [7:0] OFS_COMPARE  = 8'h34;
    // control register fields
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_UPDATE_DISABLE   = 1;
    localparam int CTRL_USRC   = 2;
    localparam int CTRL_SHOT   = 3;
    localparam int CTRL_PPRE   = 7;
    localparam int CTRL_FDIV   = 8;
    localparam int CTRL_MIRROR = 11;
    localparam logic [15:0] CTRL_MASK  = 16'h0B8F;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // mode register fields
    localparam int MODE_DIR  = 0;
    localparam int MODE_PRE  = 3;
    localparam int MODE_FLD  = 4;
    // output config / irq enable / status / event
    localparam int OUT_EN   = 0;
    localparam int OUT_POL  = 1;
    localparam int IE_UPD   = 0;
    localparam int IE_CMP   = 1;
    localparam int ST_UPD   = 0;
    localparam int ST_CMP   = 1;
    localparam int EV_UPD   = 0;
    localparam int EV_CMP   = 1;
    localparam int MIRROR_BIT = 31;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    typedef enum logic [3:0] {
        SCPT_FROZEN   = 4'h0,
        SCPT_SET_ACT  = 4'h1,
        SCPT_SET_INA  = 4'h2,
        SCPT_TOGGLE   = 4'h3,
        SCPT_FORCE_LO = 4'h4,
        SCPT_FORCE_HI = 4'h5,
        SCPT_PWM1     = 4'h6,
        SCPT_PWM2     = 4'h7
    } scpt_mode_t;
endpackage

// file: verilog/scpt_counter.sv
`timescale 1ns/1ps
// prescaler plus up counter; reinit clears both without changing the ratio
module scpt_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // control
    input  wire logic             run,
    input  wire logic             reinit,
    input  wire logic [WIDTH-1:0] psc_ratio,
    input  wire logic [WIDTH-1:0] period,
    input  wire logic             load_en,
    input  wire logic [WIDTH-1:0] load_value,
    // state
    output logic      [WIDTH-1:0] count_value,
    output logic                  overflow
);
    if (WIDTH < 2 || WIDTH > 31) begin : g_width_check
        $error("scpt_counter: WIDTH out of range");
    end

    logic [WIDTH-1:0] psc_reg;
    logic             tick;

    assign tick     = run && (psc_reg == psc_ratio);
    assign overflow = tick && (count_value >= period);

    always_ff @(posedge clock) begin
        if (!rst_b || reinit || !run) begin
            psc_reg <= '0;
        end else if (tick) begin
            psc_reg <= '0;
        end else begin
            psc_reg <= psc_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || reinit) begin
            count_value <= '0;
        end else if (load_en) begin
            count_value <= load_value;
        end else if (overflow) begin
            count_value <= '0;
        end else if (tick) begin
            count_value <= count_value + 1'b1;
        end
    end
endmodule // scpt_counter

// file: verilog/scpt_filter_clk.sv
`timescale 1ns/1ps
// filter sample strobe: one kernel clock in 1, 2 or 4
module scpt_filter_clk (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // division select
    input  wire logic [1:0] divide,
    // strobe
    output logic            sample_tick
);
    logic [1:0] div_reg;
    logic [1:0] limit;

    always_comb begin
        case (divide)
            2'h0:    limit = 2'h0;
            2'h1:    limit = 2'h1;
            2'h2:    limit = 2'h3;
            default: limit = 2'h0; // reserved code behaves as divide by one
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b || div_reg >= limit) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= (div_reg >= limit);
        end
    end
endmodule // scpt_filter_clk

// file: tb/scpt_trig_dest.sv
`timescale 1ns/1ps
// stands in for a destination timer that samples the trigger at a quarter of our rate
module scpt_trig_dest (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // trigger from the compare output
    input  wire logic        trig,
    // detected trigger edges
    output logic      [15:0] edge_count
);
    logic [1:0] div_reg;
    logic [1:0] samp_reg;

    // two high samples after a low one make an edge; a shorter pulse slips between samples
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            div_reg    <= 2'h0;
            samp_reg   <= 2'h0;
            edge_count <= 16'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) begin
                samp_reg <= {samp_reg[0], trig};
                if ({samp_reg, trig} == 3'h3) begin
                    edge_count <= edge_count + 16'h1;
                end
            end
        end
    end
endmodule // scpt_trig_dest

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clock     = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [31:0] reg_rdata;
    logic        pin;
    logic        cirq;
    logic        uirq;
    logic        fclk;
    logic [15:0] edge_count;
    logic [31:0] rnd = 32'h6ED65E0B;
    logic [31:0] d;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          hi, tg, tk, e0, cmpv;

    always #4 clock = ~clock;

    scpt_timer #(.WIDTH(16)) dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .compare_output_pin(pin), .compare_irq(cirq),
        .update_irq(uirq), .filter_sample_clock(fclk));

    scpt_trig_dest far (.clock(clock), .rst_b(rst_b), .trig(pin), .edge_count(edge_count));

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // high cycles of the reference in 100 clocks, counting 0..p at full rate
    function automatic logic [31:0] pwm_hi(int c, int p, bit m2);
        int h;
        h = (c > p) ? 100 : c * 100 / (p + 1);
        return 32'(m2 ? 100 - h : h);
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // settle past the pin latency, then watch exactly 100 clocks, ten counter periods at period 9 and full rate
    task automatic meas();
        logic pv;
        hi = 0;
        tg = 0;
        tk = 0;
        repeat (12) @(posedge clock);
        #1 pv = pin;
        e0 = int'(edge_count);
        repeat (100) begin
            @(posedge clock);
            #1 hi += int'(pin);
            tk += int'(fclk);
            tg += int'(pin != pv);
            pv = pin;
        end
    endtask

    task automatic results();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rd(scpt_pkg::OFS_CTRL, d);
        chk(d, 32'h0);
        rd(scpt_pkg::OFS_PERIOD, d);
        chk(d, 32'hFFFF);
        rd(8'hFC, d);
        chk(d, 32'h0);
        wr(scpt_pkg::OFS_CTRL, 32'hFFFF);
        rd(scpt_pkg::OFS_CTRL, d);
        chk(d, {16'h0, scpt_pkg::CTRL_MASK});
        wr(scpt_pkg::OFS_CTRL, 32'h0);
        wr(scpt_pkg::OFS_PERIOD, 32'h9);
        wr(scpt_pkg::OFS_OUTCFG, 32'h1);
        wr(scpt_pkg::OFS_COMPARE, 32'h3);
        wr(scpt_pkg::OFS_EVENT, 32'h1);
        wr(scpt_pkg::OFS_CTRL, 32'h1);
        wr(scpt_pkg::OFS_MODE, 32'h50);
        meas();
        chk(32'(hi), 32'h64);
        wr(scpt_pkg::OFS_STATUS, 32'h0);
        repeat (12) @(posedge clock);
        rd(scpt_pkg::OFS_STATUS, d);
        chk(32'(d[1]), 32'h1);
        wr(scpt_pkg::OFS_OUTCFG, 32'h3);
        meas();
        chk(32'(hi), 32'h0);
        wr(scpt_pkg::OFS_OUTCFG, 32'h1);
        wr(scpt_pkg::OFS_MODE, 32'h40);
        meas();
        chk(32'(hi), 32'h0);
        wr(scpt_pkg::OFS_MODE, 32'h51);
        meas();
        chk(32'(hi), 32'h0);
        wr(scpt_pkg::OFS_MODE, 32'h50);
        wr(scpt_pkg::OFS_OUTCFG, 32'h0);
        meas();
        chk(32'(hi), 32'h0);
        wr(scpt_pkg::OFS_OUTCFG, 32'h1);
        wr(scpt_pkg::OFS_MODE, 32'h30);
        meas();
        chk(32'(tg), 32'hA);
        chk(32'(int'(edge_count) - e0), 32'h5);
        for (int m = 2; m >= 0; m--) begin
            wr(scpt_pkg::OFS_MODE, 32'(m << 4));
            meas();
            chk(32'(hi), (m == 2) ? 32'h0 : 32'h64);
        end
        wr(scpt_pkg::OFS_IRQ_EN, 32'h2);
        wr(scpt_pkg::OFS_STATUS, 32'h0);
        repeat (14) @(posedge clock);
        #1 chk(32'(cirq), 32'h1);
        wr(scpt_pkg::OFS_IRQ_EN, 32'h0);
        repeat (3) @(posedge clock);
        #1 chk(32'(cirq), 32'h0);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            cmpv = (i < 2) ? i * 20 : int'(rnd[3:0]);
            wr(scpt_pkg::OFS_MODE, i[1] ? 32'h70 : 32'h60);
            wr(scpt_pkg::OFS_COMPARE, 32'(cmpv));
            meas();
            chk(32'(hi), pwm_hi(cmpv, 9, i[1]));
        end
        wr(scpt_pkg::OFS_MODE, 32'h60);
        wr(scpt_pkg::OFS_COMPARE, 32'h4);
        wr(scpt_pkg::OFS_MODE, 32'h68);
        wr(scpt_pkg::OFS_CTRL, 32'h3);
        wr(scpt_pkg::OFS_COMPARE, 32'h7);
        meas();
        chk(32'(hi), pwm_hi(4, 9, 1'b0));
        wr(scpt_pkg::OFS_CTRL, 32'h1);
        wr(scpt_pkg::OFS_EVENT, 32'h1);
        meas();
        chk(32'(hi), pwm_hi(7, 9, 1'b0));
        wr(scpt_pkg::OFS_CTRL, 32'h83);
        wr(scpt_pkg::OFS_PERIOD, 32'h4);
        meas();
        chk(32'(hi), pwm_hi(7, 9, 1'b0));
        wr(scpt_pkg::OFS_CTRL, 32'h81);
        meas();
        chk(32'(hi), pwm_hi(7, 4, 1'b0));
        wr(scpt_pkg::OFS_PERIOD, 32'h9);
        wr(scpt_pkg::OFS_CTRL, 32'h4);
        wr(scpt_pkg::OFS_COUNT, 32'h5);
        rd(scpt_pkg::OFS_COUNT, d);
        chk(d, 32'h5);
        wr(scpt_pkg::OFS_STATUS, 32'h0);
        wr(scpt_pkg::OFS_EVENT, 32'h1);
        rd(scpt_pkg::OFS_COUNT, d);
        chk(d, 32'h0);
        rd(scpt_pkg::OFS_STATUS, d);
        chk(32'(d[0]), 32'h0);
        wr(scpt_pkg::OFS_EVENT, 32'h2);
        rd(scpt_pkg::OFS_STATUS, d);
        chk(d, 32'h2);
        wr(scpt_pkg::OFS_CTRL, 32'h0);
        wr(scpt_pkg::OFS_EVENT, 32'h1);
        rd(scpt_pkg::OFS_STATUS, d);
        chk(32'(d[0]), 32'h1);
        wr(scpt_pkg::OFS_IRQ_EN, 32'h1);
        @(posedge clock);
        #1 chk(32'(uirq), 32'h1);
        wr(scpt_pkg::OFS_CTRL, 32'h800);
        rd(scpt_pkg::OFS_COUNT, d);
        chk(d, 32'h80000000);
        wr(scpt_pkg::OFS_STATUS, 32'h0);
        rd(scpt_pkg::OFS_COUNT, d);
        chk(d, 32'h0);
        chk(32'(uirq), 32'h0);
        wr(scpt_pkg::OFS_CTRL, 32'h9);
        repeat (30) @(posedge clock);
        rd(scpt_pkg::OFS_CTRL, d);
        chk(d, 32'h8);
        for (int i = 0; i < 4; i++) begin
            wr(scpt_pkg::OFS_CTRL, 32'(i << 8));
            meas();
            chk(32'(tk), (i == 3) ? 32'h64 : 32'(100 >> i));
        end
        results();
    end
endmodule // tb
